// file: exc_classifier.sv
// Exception classifier for breakpoint, overflow, range and invalid-opcode events
//
// Function
// - One-byte breakpoint instruction raises vector 3 as a trap.
// - Software interrupt with immediate 3 also raises the breakpoint trap.
// - Breakpoint trap saves the pointer of the following instruction.
// - Breakpoint instruction writes no register or memory.
// - Overflow check traps on vector 4 only when signed overflow flag set.
// - Overflow trap saves the pointer of the following instruction.
// - Add and subtract set signed overflow and carry flags together.
// - Overflow check instruction writes no register or memory.
// - Bound check with signed index outside bounds raises fault vector 5.
// - Range fault saves the checking instruction pointer, operands untouched.
// - Invalid or reserved opcode faults on vector 6, not executed, own pointer.
// - Illegal operand type, such as far load from register, faults invalid.
// - Packed or streaming instruction of absent extension faults invalid.
// - Packed or streaming instruction with no-coprocessor set faults, listed exempt.
// - Streaming instruction with state-save enable clear faults, listed exempt.
// - Floating exception with exception enable clear becomes invalid-opcode fault.
// - Forced undefined instruction always faults, pointer names itself.
// - Lock prefix on unlockable or register-destination instruction faults.
// - Descriptor-table and related instructions fault in real or virtual mode.
// - Mode return instruction faults outside system management mode.
// - Invalid-opcode fault only at retirement, never from speculation.
// - Reserved opcodes D6 and F1 do not fault.
//
// The implementer's own choices: the APB slave port and the register offsets.

`timescale 1ns/1ps

module exc_classifier
(
  input  wire logic            core_clk,
  input  wire logic            resetn,
  input  wire logic            ce,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Arithmetic flag update
  input  wire logic            alu_valid,
  input  wire logic            alu_sub,
  input  wire logic [31:0]     alu_a,
  input  wire logic [31:0]     alu_b,
  // Retirement port
  input  wire logic            ret_valid,
  input  wire exc_pkg::iclass_t ret_class,
  input  wire exc_pkg::ext_t   ret_ext,
  input  wire logic [7:0]      ret_opcode,
  input  wire logic [7:0]      ret_imm,
  input  wire logic [31:0]     ret_ip,
  input  wire logic [31:0]     ret_next_ip,
  input  wire logic            ret_lock,
  input  wire logic            ret_lockable,
  input  wire logic            ret_dest_mem,
  input  wire logic            ret_src_mem,
  input  wire logic            ret_em_exempt,
  input  wire logic            ret_fxsr_exempt,
  input  wire logic            ret_simd_fp_exc,
  input  wire logic [31:0]     ret_index,
  input  wire logic [31:0]     ret_lower,
  input  wire logic [31:0]     ret_upper,
  // Processor mode
  input  wire logic            real_mode,
  input  wire logic            v86_mode,
  input  wire logic            system_management_mode,
  // Exception delivery
  output logic                 exc_valid,
  output logic [7:0]           exc_vector,
  output logic                 exc_trap,
  output logic                 exc_soft_int,
  output logic                 exc_push_err,
  output logic [31:0]          saved_instruction_pointer,
  // Normal retirement
  output logic                 commit_valid,
  output logic                 commit_wr_en,
  // Arithmetic flags
  output logic                 signed_overflow_flag,
  output logic                 unsigned_carry_flag
);

  import exc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic map_hit(input logic [11:0] a);
    map_hit = (a == OFS_CTRL) || (a == OFS_FEAT) || (a == OFS_EXTFEAT)
              || (a == OFS_STATUS) || (a == OFS_FLAGS);
  endfunction : map_hit

  function automatic logic ext_present(input ext_t e,
                                       input logic [31:0] f,
                                       input logic [31:0] x);
    case (e)
      EXT_NONE:       ext_present = 1'b1;
      EXT_PACKED_INT: ext_present = f[FEAT_PACKED];
      EXT_STREAM_1:   ext_present = f[FEAT_STREAM1];
      EXT_STREAM_2:   ext_present = f[FEAT_STREAM2];
      EXT_STREAM_3:   ext_present = x[EXT_STREAM3];
      EXT_STREAM_4:   ext_present = x[EXT_STREAM4];
      default:        ext_present = 1'b0;
    endcase
  endfunction : ext_present

  function automatic logic is_stream(input ext_t e);
    is_stream = (e == EXT_STREAM_1) || (e == EXT_STREAM_2)
                || (e == EXT_STREAM_3) || (e == EXT_STREAM_4);
  endfunction : is_stream

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t st_q;
  state_t st_d;

  always_comb
  begin
    logic [32:0] sum;
    logic        ovf_new;
    logic        ud;
    logic        out_of_range;
    logic        rsvd_opc;
    logic        apb_wr;
    sum          = 33'h0_0000_0000;
    ovf_new      = 1'b0;
    ud           = 1'b0;
    out_of_range = 1'b0;
    rsvd_opc     = 1'b0;
    apb_wr       = 1'b0;
    st_d         = st_q;

    if (ce)
    begin
      // Pulses last one enabled cycle
      st_d.exc_valid = 1'b0;
      st_d.commit    = 1'b0;
      st_d.wr_en     = 1'b0;
      st_d.pready    = 1'b0;
      st_d.pslverr   = 1'b0;

      //////////////////////////////////////////////////////////////////////
      // Arithmetic flags: both come from the same result
      if (alu_valid)
      begin
        if (alu_sub)
        begin
          sum     = {1'b0, alu_a} - {1'b0, alu_b};
          ovf_new = (alu_a[31] != alu_b[31]) && (sum[31] != alu_a[31]);
        end
        else
        begin
          sum     = {1'b0, alu_a} + {1'b0, alu_b};
          ovf_new = (alu_a[31] == alu_b[31]) && (sum[31] != alu_a[31]);
        end
        st_d.ovf = ovf_new;
        st_d.cry = sum[32];
      end

      //////////////////////////////////////////////////////////////////////
      // Classification happens only on the retirement port, so a wrong-path
      // instruction never reaches it and cannot fault
      if (ret_valid)
      begin
        rsvd_opc = (ret_opcode == OPC_RSVD_A) || (ret_opcode == OPC_RSVD_B);
        ud = ((ret_class == IC_UNDEFINED) && !rsvd_opc)
          || ((ret_class == IC_FAR_LOAD) && !ret_src_mem)
          || !ext_present(ret_ext, st_q.feat, st_q.extfeat)
          || ((ret_ext != EXT_NONE) && st_q.ctrl[CTRL_NO_COPROC]
              && !ret_em_exempt)
          || (is_stream(ret_ext) && !st_q.ctrl[CTRL_FXSR_EN]
              && !ret_fxsr_exempt)
          || (ret_simd_fp_exc && !st_q.ctrl[CTRL_XMMEXC_EN])
          || (ret_class == IC_FORCED_UD)
          || (ret_lock && (!ret_lockable || !ret_dest_mem))
          || ((ret_class == IC_SYS_TABLE) && (real_mode || v86_mode))
          || ((ret_class == IC_MODE_RETURN) && !system_management_mode);
        out_of_range = ($signed(ret_index) < $signed(ret_lower))
                    || ($signed(ret_index) > $signed(ret_upper));

        st_d.push_err = 1'b0;
        st_d.soft_int = 1'b0;

        if (ud)
        begin
          // Fault: nothing executes, pointer names the offender
          st_d.exc_valid = 1'b1;
          st_d.vec       = VEC_INVALID;
          st_d.trap      = 1'b0;
          st_d.saved_ip  = ret_ip;
        end
        else if ((ret_class == IC_BOUND) && out_of_range)
        begin
          // Fault keeps the operands so the handler return restarts the check
          st_d.exc_valid = 1'b1;
          st_d.vec       = VEC_RANGE;
          st_d.trap      = 1'b0;
          st_d.saved_ip  = ret_ip;
        end
        else if ((ret_class == IC_OVF_CHECK) && st_q.ovf)
        begin
          st_d.exc_valid = 1'b1;
          st_d.vec       = VEC_OVERFLOW;
          st_d.trap      = 1'b1;
          st_d.saved_ip  = ret_next_ip;
        end
        else if ((ret_class == IC_BREAK1)
                 || ((ret_class == IC_SOFT_INT) && (ret_imm == SOFT_INT_BP_IMM)))
        begin
          st_d.exc_valid = 1'b1;
          st_d.vec       = VEC_BREAKPOINT;
          st_d.trap      = 1'b1;
          st_d.soft_int  = (ret_class == IC_SOFT_INT);
          st_d.saved_ip  = ret_next_ip;
        end
        else if (!ret_simd_fp_exc)
        begin
          // An enabled floating exception belongs to other delivery logic
          st_d.commit = 1'b1;
          // Overflow check and a bound check in range leave no results behind
          st_d.wr_en  = (ret_class != IC_OVF_CHECK) && (ret_class != IC_BOUND);
        end

        if (st_d.exc_valid)
        begin
          // Traps and faults alike suppress any writeback
          st_d.wr_en    = 1'b0;
          st_d.last_vec = st_d.vec;
          st_d.exc_cnt  = st_q.exc_cnt + 16'h0001;
        end
      end

      //////////////////////////////////////////////////////////////////////
      // APB slave: no wait state, answer registered in the setup cycle and shown in the access cycle
      if (psel && !penable)
      begin
        st_d.pready  = 1'b1;
        st_d.pslverr = !map_hit(paddr);
        st_d.prdata  = 32'h0000_0000;
        if (!pwrite)
        begin
          case (paddr)
            OFS_CTRL:    st_d.prdata = {29'h0000_0000, st_q.ctrl};
            OFS_FEAT:    st_d.prdata = st_q.feat;
            OFS_EXTFEAT: st_d.prdata = st_q.extfeat;
            OFS_STATUS:
            begin
              st_d.prdata[STAT_VEC_LSB +: 8]  = st_q.last_vec;
              st_d.prdata[STAT_CNT_LSB +: 16] = st_q.exc_cnt;
            end
            OFS_FLAGS:
            begin
              st_d.prdata[FLG_OVF] = st_q.ovf;
              st_d.prdata[FLG_CRY] = st_q.cry;
            end
            default:     st_d.prdata = 32'h0000_0000;
          endcase
        end
      end

      apb_wr = psel && penable && pwrite && st_q.pready && map_hit(paddr);
      if (apb_wr)
      begin
        case (paddr)
          OFS_CTRL:    st_d.ctrl    = pwdata[CTRL_W-1:0];
          OFS_FEAT:    st_d.feat    = pwdata;
          OFS_EXTFEAT: st_d.extfeat = pwdata;
          default:     st_d.ctrl    = st_d.ctrl;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      st_q         <= '0;
      st_q.ctrl    <= CTRL_RST;
      st_q.feat    <= FEAT_RST;
      st_q.extfeat <= EXTFEAT_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign prdata                    = st_q.prdata;
  assign pready                    = st_q.pready;
  assign pslverr                   = st_q.pslverr;
  assign exc_valid                 = st_q.exc_valid;
  assign exc_vector                = st_q.vec;
  assign exc_trap                  = st_q.trap;
  assign exc_soft_int              = st_q.soft_int;
  assign exc_push_err              = st_q.push_err;
  assign saved_instruction_pointer = st_q.saved_ip;
  assign commit_valid              = st_q.commit;
  assign commit_wr_en              = st_q.wr_en;
  assign signed_overflow_flag      = st_q.ovf;
  assign unsigned_carry_flag       = st_q.cry;

endmodule : exc_classifier

// file: exc_pkg.sv
// Shared constants and types for the exception classifier for vectors three to six
package exc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Exception vectors
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW   = 8'h04;
  localparam logic [7:0] VEC_RANGE      = 8'h05;
  localparam logic [7:0] VEC_INVALID    = 8'h06;

  // Immediate of the general software interrupt that maps to the breakpoint
  localparam logic [7:0] SOFT_INT_BP_IMM = 8'h03;

  // Reserved undefined opcodes that retire without a fault
  localparam logic [7:0] OPC_RSVD_A = 8'hD6;
  localparam logic [7:0] OPC_RSVD_B = 8'hF1;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_FEAT    = 12'h004;
  localparam logic [11:0] OFS_EXTFEAT = 12'h008;
  localparam logic [11:0] OFS_STATUS  = 12'h00C;
  localparam logic [11:0] OFS_FLAGS   = 12'h010;

  // Control register fields
  localparam int CTRL_NO_COPROC = 0;
  localparam int CTRL_FXSR_EN   = 1;
  localparam int CTRL_XMMEXC_EN = 2;
  localparam int CTRL_W         = 3;

  // Feature identification bit positions
  localparam int FEAT_PACKED  = 23;
  localparam int FEAT_STREAM1 = 25;
  localparam int FEAT_STREAM2 = 26;
  localparam int EXT_STREAM3  = 0;
  localparam int EXT_STREAM4  = 9;

  // Status register fields
  localparam int STAT_VEC_LSB = 0;
  localparam int STAT_CNT_LSB = 16;

  // Flags register fields
  localparam int FLG_OVF = 0;
  localparam int FLG_CRY = 1;

  // Reset values
  localparam logic [2:0]  CTRL_RST    = 3'h0;
  localparam logic [31:0] FEAT_RST    = 32'h0680_0000;
  localparam logic [31:0] EXTFEAT_RST = 32'h0000_0201;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction class reported by decode at retirement
  typedef enum logic [3:0] {
    IC_PLAIN, IC_BREAK1, IC_SOFT_INT, IC_OVF_CHECK, IC_BOUND, IC_FAR_LOAD,
    IC_FORCED_UD, IC_MODE_RETURN, IC_SYS_TABLE, IC_UNDEFINED
  } iclass_t;

  // Instruction set extension of the retiring instruction
  typedef enum logic [2:0] {
    EXT_NONE, EXT_PACKED_INT, EXT_STREAM_1, EXT_STREAM_2, EXT_STREAM_3, EXT_STREAM_4
  } ext_t;

  // Whole state of the classifier
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]       feat;
    logic [31:0]       extfeat;
    logic              ovf;
    logic              cry;
    logic              exc_valid;
    logic [7:0]        vec;
    logic              trap;
    logic              soft_int;
    logic              push_err;
    logic [31:0]       saved_ip;
    logic              commit;
    logic              wr_en;
    logic [7:0]        last_vec;
    logic [15:0]       exc_cnt;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } state_t;

endpackage : exc_pkg

// file: exc_classifier_sva.sv
// Port-level checks for the exception classifier
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module exc_checker
(
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             ce,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             ret_valid,
  input wire exc_pkg::iclass_t ret_class,
  input wire exc_pkg::ext_t    ret_ext,
  input wire logic [7:0]       ret_imm,
  input wire logic [31:0]      ret_ip,
  input wire logic [31:0]      ret_next_ip,
  input wire logic             ret_lock,
  input wire logic             exc_valid,
  input wire logic [7:0]       exc_vector,
  input wire logic             exc_trap,
  input wire logic             exc_soft_int,
  input wire logic             exc_push_err,
  input wire logic [31:0]      saved_instruction_pointer,
  input wire logic             commit_valid,
  input wire logic             commit_wr_en,
  input wire logic             signed_overflow_flag
);
  import exc_pkg::*;
  logic go;
  // Only plain, unlocked retirements: anything else may be overridden by a higher-priority fault
  assign go = ce && ret_valid && !ret_lock && ret_ext == EXT_NONE;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
////////////////////////////////////////////////////////////////////////////////
  a_bp_trap:
  assert property (go && ret_class == IC_BREAK1 |=> exc_valid && exc_vector == VEC_BREAKPOINT && exc_trap
    && saved_instruction_pointer == $past(ret_next_ip)) else $error("breakpoint trap wrong");
  a_soft_break:
  assert property (go && ret_class == IC_SOFT_INT && ret_imm == SOFT_INT_BP_IMM |=> exc_valid
    && exc_vector == VEC_BREAKPOINT && exc_soft_int) else $error("soft breakpoint wrong");
  a_no_error_code:
  assert property (exc_valid |-> !exc_push_err) else $error("error code pushed");
  a_ovf_trap:
  assert property (go && ret_class == IC_OVF_CHECK && signed_overflow_flag |=> exc_valid && exc_trap
    && exc_vector == VEC_OVERFLOW && saved_instruction_pointer == $past(ret_next_ip)) else $error("overflow trap wrong");
  a_ovf_pass:
  assert property (go && ret_class == IC_OVF_CHECK && !signed_overflow_flag |=> commit_valid && !commit_wr_en
    && !exc_valid) else $error("overflow check not passed");
  a_forced_fault:
  assert property (go && ret_class == IC_FORCED_UD |=> exc_valid && exc_vector == VEC_INVALID && !exc_trap
    && saved_instruction_pointer == $past(ret_ip)) else $error("forced undefined wrong");
  a_retire_only:
  assert property (exc_valid |-> $past(ret_valid) && $past(ce)) else $error("exception without retirement");
  a_apb_wait:
  assert property (ce && psel && !penable |=> pready ##1 !pready) else $error("apb answer timing wrong");
  c_bp: cover property (exc_valid && exc_vector == VEC_BREAKPOINT);
  c_ovf: cover property (exc_valid && exc_vector == VEC_OVERFLOW);
  c_apb: cover property (psel && penable && pready);
endmodule : exc_checker

bind exc_classifier exc_checker u_chk (.*);

// file: retire_pipe_model.sv
// Retirement stage stand-in presenting one instruction per call
`timescale 1ns/1ps
module retire_pipe_model
#(
  parameter logic [31:0] INSTR_LEN = 32'h0000_0002
)
(
  input  wire logic        core_clk,
  output logic             ret_valid,
  output exc_pkg::iclass_t ret_class,
  output exc_pkg::ext_t    ret_ext,
  output logic [7:0]       ret_opcode,
  output logic [7:0]       ret_imm,
  output logic [31:0]      ret_ip,
  output logic [31:0]      ret_next_ip,
  output logic             ret_lock
);
  import exc_pkg::*;
  initial
  begin
    ret_valid = 1'h0;
    ret_class = IC_PLAIN;
    ret_ext = EXT_NONE;
    ret_opcode = 8'h00;
    ret_imm = 8'h00;
    ret_ip = 32'h0;
    ret_next_ip = 32'h0;
    ret_lock = 1'h0;
  end
  // Called right after a rising edge; returns after the edge that takes it
  task automatic retire(input iclass_t c, input ext_t e, input logic [7:0] op, input logic lk,
                        input logic [31:0] ip);
    ret_valid <= 1'h1;
    ret_class <= c;
    ret_ext <= e;
    ret_opcode <= op;
    ret_imm <= op;
    ret_ip <= ip;
    ret_next_ip <= ip + INSTR_LEN;
    ret_lock <= lk;
    @(posedge core_clk);
    // Released fields flip so a late sample cannot match by luck
    ret_valid <= 1'h0;
    ret_opcode <= ~op;
    ret_imm <= ~op;
    ret_ip <= ~ip;
    ret_next_ip <= ~ip;
    ret_lock <= ~lk;
  endtask : retire
endmodule : retire_pipe_model

// file: trap_fault_vectors_three_to_six_bench.sv
// Self-checking bench for the exception classifier
`timescale 1ns/1ps
module trap_fault_vectors_three_to_six_bench;
  import exc_pkg::*;
  localparam logic [31:0] ILEN = 32'h0000_0002;
  logic core_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic alu_valid = 1'h0, alu_sub = 1'h0, ret_lockable = 1'h0, ret_dest_mem = 1'h0;
  logic ret_simd_fp_exc = 1'h0, real_mode = 1'h0, system_management_mode = 1'h0;
  logic v86_mode = 1'h0, ret_src_mem = 1'h0, ret_em_exempt = 1'h0, ret_fxsr_exempt = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, alu_a = 32'h0, alu_b = 32'h0, ret_index = 32'h0;
  logic [31:0] ret_lower = 32'h0, ret_upper = 32'h0, ip = 32'h0, last_ip = 32'h0, rd;
  logic [31:0] prdata, ret_ip, ret_next_ip, saved_instruction_pointer;
  logic pready, pslverr, ret_valid, ret_lock, exc_valid, exc_trap, exc_soft_int, exc_push_err;
  logic commit_valid, commit_wr_en, signed_overflow_flag, unsigned_carry_flag, err;
  logic [7:0] ret_opcode, ret_imm, exc_vector, lvec = 8'h00;
  logic [31:0] bidx [4] = '{32'hFFFF_FFFF, 32'h0, 32'h0000_000A, 32'h0000_000B};
  logic [7:0] bvec [4] = '{8'h05, 8'h00, 8'h00, 8'h05};
  exc_pkg::iclass_t ret_class;
  exc_pkg::ext_t ret_ext;
  int mismatches = 0, total_checks = 0, cycles = 0, nexc = 0;

  exc_classifier i_dut (.ce(1'h1), .*);
  retire_pipe_model #(.INSTR_LEN(ILEN)) i_pipe (.*);

  always #12.5 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Starts and ends right after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    // Answer and read data are taken at the rising edge that shows pready high
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge so a following call never re-raises psel in the same step
    @(posedge core_clk);
  endtask : apb

  task automatic alu(input logic s, input logic [31:0] a, input logic [31:0] b);
    logic [32:0] r;
    logic [32:0] w;
    r = s ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b};
    // Sign-extended result: signed overflow when the two top bits differ
    w = s ? {a[31], a} - {b[31], b} : {a[31], a} + {b[31], b};
    alu_valid <= 1'h1;
    alu_sub <= s;
    alu_a <= a;
    alu_b <= b;
    @(posedge core_clk);
    alu_valid <= 1'h0;
    @(negedge core_clk);
    chk({signed_overflow_flag, unsigned_carry_flag}, {w[32] != w[31], r[32]});
    @(posedge core_clk);
  endtask : alu

  // Vector 00 means a normal retirement, FF means neither answer; wr of x leaves write enable unchecked only for vector 00
  task automatic rt(input iclass_t c, input ext_t e, input logic [7:0] op, input logic [7:0] v, input logic lk,
                    input logic wr);
    logic x;
    logic ex;
    logic [45:0] g;
    ip = ip + 32'h10;
    ex = v != 8'h00 && v != 8'hFF;
    if (ex)
    begin
      lvec = v;
      last_ip = (v < 8'h05) ? ip + ILEN : ip;
      nexc++;
    end
    i_pipe.retire(c, e, op, lk, ip);
    @(negedge core_clk);
    x = (wr === 1'hx) ? commit_wr_en : wr;
    g = {exc_valid, exc_vector, exc_trap, exc_soft_int, exc_push_err, commit_valid, commit_wr_en,
         saved_instruction_pointer};
    chk(g, {ex, lvec, lvec < 8'h05, c == IC_SOFT_INT && v == 8'h03, 1'h0, v == 8'h00, v == 8'h00 && x,
            last_ip});
    @(posedge core_clk);
  endtask : rt
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    apb(1'h0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, OFS_FEAT, 32'h0);
    chk(rd, FEAT_RST);
    apb(1'h0, OFS_EXTFEAT, 32'h0);
    chk(rd, EXTFEAT_RST);
    apb(1'h0, 12'h014, 32'h0);
    chk({err, rd}, {1'h1, 32'h0});
    rt(IC_BREAK1, EXT_NONE, 8'h00, 8'h03, 1'h0, 1'hx);
    rt(IC_SOFT_INT, EXT_NONE, 8'h03, 8'h03, 1'h0, 1'hx);
    rt(IC_SOFT_INT, EXT_NONE, 8'h04, 8'h00, 1'h0, 1'h1);
    alu(1'h0, 32'h7FFF_FFFF, 32'h0000_0001);
    rt(IC_OVF_CHECK, EXT_NONE, 8'h00, 8'h04, 1'h0, 1'hx);
    alu(1'h1, 32'h0000_0000, 32'h0000_0001);
    rt(IC_OVF_CHECK, EXT_NONE, 8'h00, 8'h00, 1'h0, 1'h0);
    alu(1'h1, 32'h8000_0000, 32'h0000_0001);
    apb(1'h0, OFS_FLAGS, 32'h0);
    chk(rd[1:0], 2'h1);
    ret_upper <= 32'h0000_000A;
    foreach (bidx[i])
    begin
      ret_index <= bidx[i];
      rt(IC_BOUND, EXT_NONE, 8'h00, bvec[i], 1'h0, 1'h0);
    end
    rt(IC_UNDEFINED, EXT_NONE, 8'h0B, 8'h06, 1'h0, 1'hx);
    rt(IC_UNDEFINED, EXT_NONE, OPC_RSVD_A, 8'h00, 1'h0, 1'h1);
    rt(IC_UNDEFINED, EXT_NONE, OPC_RSVD_B, 8'h00, 1'h0, 1'h1);
    rt(IC_FORCED_UD, EXT_NONE, 8'h00, 8'h06, 1'h0, 1'hx);
    rt(IC_FAR_LOAD, EXT_NONE, 8'h00, 8'h06, 1'h0, 1'hx);
    ret_src_mem <= 1'h1;
    rt(IC_FAR_LOAD, EXT_NONE, 8'h00, 8'h00, 1'h0, 1'h1);
    rt(IC_PLAIN, EXT_NONE, 8'h00, 8'h06, 1'h1, 1'hx);
    ret_lockable <= 1'h1;
    rt(IC_PLAIN, EXT_NONE, 8'h00, 8'h06, 1'h1, 1'hx);
    ret_dest_mem <= 1'h1;
    rt(IC_PLAIN, EXT_NONE, 8'h00, 8'h00, 1'h1, 1'h1);
    real_mode <= 1'h1;
    rt(IC_SYS_TABLE, EXT_NONE, 8'h00, 8'h06, 1'h0, 1'hx);
    real_mode <= 1'h0;
    rt(IC_SYS_TABLE, EXT_NONE, 8'h00, 8'h00, 1'h0, 1'h1);
    v86_mode <= 1'h1;
    rt(IC_SYS_TABLE, EXT_NONE, 8'h00, 8'h06, 1'h0, 1'hx);
    v86_mode <= 1'h0;
    rt(IC_MODE_RETURN, EXT_NONE, 8'h00, 8'h06, 1'h0, 1'hx);
    system_management_mode <= 1'h1;
    rt(IC_MODE_RETURN, EXT_NONE, 8'h00, 8'h00, 1'h0, 1'h1);
    rt(IC_PLAIN, EXT_PACKED_INT, 8'h00, 8'h00, 1'h0, 1'h1);
    apb(1'h1, OFS_FEAT, 32'h0);
    rt(IC_PLAIN, EXT_PACKED_INT, 8'h00, 8'h06, 1'h0, 1'hx);
    apb(1'h1, OFS_FEAT, FEAT_RST);
    apb(1'h1, OFS_CTRL, 32'h1);
    rt(IC_PLAIN, EXT_PACKED_INT, 8'h00, 8'h06, 1'h0, 1'hx);
    ret_em_exempt <= 1'h1;
    rt(IC_PLAIN, EXT_PACKED_INT, 8'h00, 8'h00, 1'h0, 1'h1);
    ret_em_exempt <= 1'h0;
    apb(1'h1, OFS_CTRL, 32'h0);
    rt(IC_PLAIN, EXT_STREAM_1, 8'h00, 8'h06, 1'h0, 1'hx);
    ret_fxsr_exempt <= 1'h1;
    rt(IC_PLAIN, EXT_STREAM_1, 8'h00, 8'h00, 1'h0, 1'h1);
    ret_fxsr_exempt <= 1'h0;
    apb(1'h1, OFS_CTRL, 32'h2);
    rt(IC_PLAIN, EXT_STREAM_1, 8'h00, 8'h00, 1'h0, 1'h1);
    apb(1'h1, OFS_EXTFEAT, 32'h0);
    rt(IC_PLAIN, EXT_STREAM_3, 8'h00, 8'h06, 1'h0, 1'hx);
    ret_simd_fp_exc <= 1'h1;
    rt(IC_PLAIN, EXT_STREAM_2, 8'h00, 8'h06, 1'h0, 1'hx);
    apb(1'h1, OFS_CTRL, 32'h6);
    rt(IC_PLAIN, EXT_STREAM_2, 8'h00, 8'hFF, 1'h0, 1'hx);
    ret_simd_fp_exc <= 1'h0;
    apb(1'h0, OFS_STATUS, 32'h0);
    chk(rd, {nexc[15:0], 8'h00, lvec});
    finish_test();
  end
endmodule : trap_fault_vectors_three_to_six_bench
